// ===== lam_pkg.sv
// Purpose: Shared constants for the line alarm monitor.
// Assumes: One 25 MHz clock; APB register access with 32-bit data.
// Notes: Offsets are byte addresses of aligned words.
package lam_pkg;
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned DPM_LIMIT = 63;
	localparam int unsigned LOS_LIMIT = 175;
	localparam int unsigned BIT_DIV = 16;
	localparam int unsigned TX_DIV = 16;
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_MASK = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_LIVE = 8'h0C;
	localparam int unsigned BIT_LOS = 0;
	localparam int unsigned BIT_DPM = 1;
	localparam int unsigned LIVE_MODE = 2;
	localparam int unsigned LIVE_EQ_LSB = 4;
	localparam logic [1:0] MASK_RESET = 2'h3;
	localparam logic [2:0] EQ_RESET = 3'h0;
endpackage : lam_pkg

// ===== lam_gap_count.sv
// Purpose: Counts clock enable ticks without a pulse and raises an alarm at a limit.
// Assumes: Pulse and tick are synchronous to clk.
// Notes: A pulse clears the count and the alarm at once.
`timescale 1ns/1ns
module lam_gap_count #(
	parameter int unsigned LIMIT = 63,
	parameter int unsigned W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Events
	input wire logic tick,
	input wire logic pulse,
	// Results
	output logic alarm,
	output logic [W-1:0] count
);
	localparam logic [W-1:0] LIM = W'(LIMIT);
	wire at_limit = (count == LIM);
	wire [W-1:0] next_count = pulse ? '0 : (tick && !at_limit) ? count + 1'b1 : count;

	always_ff @(posedge clk) begin
		if (rst) begin
			count <= '0;
			alarm <= 1'b0;
		end else begin
			count <= next_count;
			alarm <= !pulse && (next_count == LIM);
		end
	end
endmodule : lam_gap_count

// ===== lam_line_alarm_monitor.sv
// Purpose: Loss of signal and driver monitor alarms with interrupt and equalizer select.
// Assumes: Line and pin inputs are digital levels synchronous to ref_clk.
// Notes: Interrupt is open drain, shown as output value and enable.
`timescale 1ns/1ns
module lam_line_alarm_monitor import lam_pkg::*; #(
	parameter int unsigned BIT_DIVIDE = BIT_DIV,
	parameter int unsigned TX_DIVIDE = TX_DIV
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Line side
	input wire logic monitor_line_a,
	input wire logic monitor_line_b,
	input wire logic receive_line_a,
	input wire logic receive_line_b,
	output logic rx_plus_data,
	output logic rx_minus_data,
	output logic rx_clk,
	// Pins
	input wire logic mode_host,
	input wire logic eq_select_0,
	input wire logic eq_select_1,
	input wire logic eq_select_2,
	output logic [2:0] eq_code,
	output logic driver_perf_alarm,
	output logic signal_loss_alarm,
	output logic int_out,
	output logic int_oe
);
	localparam logic [7:0] BDIV = 8'(BIT_DIVIDE);
	localparam logic [7:0] TDIV = 8'(TX_DIVIDE);
	localparam logic [6:0] DPM_LO = 7'(DPM_LIMIT - 2);
	localparam logic [6:0] DPM_HI = 7'(DPM_LIMIT + 2);
	localparam logic [7:0] LOS_TICKS = 8'(LOS_LIMIT);
	localparam int RX_SPAN = int'(BIT_DIVIDE) + 1;

	logic [7:0] tx_div_cnt;
	logic [7:0] rx_phase;
	logic rx_mark_d;
	logic plus_seen;
	logic minus_seen;
	logic dpm_live;
	logic los_live;
	logic dpm_live_d;
	logic los_live_d;
	logic [1:0] status;
	logic [1:0] mask;
	logic [2:0] eq_ctrl;
	logic [5:0] dpm_cnt;
	logic [7:0] los_cnt;

	// Transmit period and bit period enables.
	wire tx_tick = (tx_div_cnt == TDIV - 8'h01);
	wire rx_bit_en = (rx_phase == BDIV - 8'h01);
	wire dpm_pulse = monitor_line_a || monitor_line_b;
	wire rx_mark = receive_line_a || receive_line_b;
	wire mark_rise = rx_mark && !rx_mark_d;

	lam_gap_count #(.LIMIT(DPM_LIMIT), .W(6)) u_dpm (
		.clk(ref_clk),
		.rst(sys_rst),
		.tick(tx_tick),
		.pulse(dpm_pulse),
		.alarm(dpm_live),
		.count(dpm_cnt)
	);

	lam_gap_count #(.LIMIT(LOS_LIMIT), .W(8)) u_los (
		.clk(ref_clk),
		.rst(sys_rst),
		.tick(rx_bit_en),
		.pulse(rx_mark),
		.alarm(los_live),
		.count(los_cnt)
	);

	// APB decode.
	wire apb_access = psel && penable && !pready;
	wire hit_status = (paddr == OFS_STATUS);
	wire hit_mask = (paddr == OFS_MASK);
	wire hit_ctrl = (paddr == OFS_CTRL);
	wire hit_live = (paddr == OFS_LIVE);
	wire addr_ok = hit_status || hit_mask || hit_ctrl || hit_live;
	wire wr_en = apb_access && pwrite && addr_ok;
	wire [1:0] w1c = (wr_en && hit_status) ? pwdata[1:0] : 2'h0;
	wire [1:0] rise_ev = {dpm_live && !dpm_live_d, los_live && !los_live_d};
	wire [1:0] next_status = rise_ev | (status & ~w1c);
	wire [31:0] live_word = {25'h0, eq_code, 1'b0, mode_host, dpm_live, los_live};
	wire [31:0] rd_word = hit_status ? {30'h0, status} :
		hit_mask ? {30'h0, mask} :
		hit_ctrl ? {29'h0, eq_ctrl} :
		hit_live ? live_word : 32'h0;
	wire [2:0] pin_code = {eq_select_2, eq_select_1, eq_select_0};
	wire [2:0] next_eq = mode_host ? eq_ctrl : pin_code;
	wire next_int = mode_host && |(next_status & mask);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			status <= 2'h0;
			mask <= MASK_RESET;
			eq_ctrl <= EQ_RESET;
		end else begin
			pready <= apb_access;
			pslverr <= apb_access && !addr_ok;
			prdata <= (apb_access && !pwrite) ? rd_word : 32'h0;
			status <= next_status;
			if (wr_en && hit_mask) begin
				mask <= pwdata[1:0];
			end
			if (wr_en && hit_ctrl) begin
				eq_ctrl <= pwdata[2:0];
			end
		end
	end

	// Clock recovery: phase realigns on each mark so sampling sits mid bit.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_div_cnt <= 8'h0;
			rx_phase <= 8'h0;
			rx_mark_d <= 1'b0;
			plus_seen <= 1'b0;
			minus_seen <= 1'b0;
			rx_plus_data <= 1'b0;
			rx_minus_data <= 1'b0;
			rx_clk <= 1'b0;
		end else begin
			tx_div_cnt <= tx_tick ? 8'h0 : tx_div_cnt + 8'h01;
			rx_mark_d <= rx_mark;
			if (mark_rise) begin
				rx_phase <= BDIV >> 1;
			end else begin
				rx_phase <= rx_bit_en ? 8'h0 : rx_phase + 8'h01;
			end
			rx_clk <= (rx_phase < (BDIV >> 1));
			if (rx_bit_en) begin
				rx_plus_data <= plus_seen || receive_line_a;
				rx_minus_data <= minus_seen || receive_line_b;
				plus_seen <= 1'b0;
				minus_seen <= 1'b0;
			end else begin
				plus_seen <= plus_seen || receive_line_a;
				minus_seen <= minus_seen || receive_line_b;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			dpm_live_d <= 1'b0;
			los_live_d <= 1'b0;
			driver_perf_alarm <= 1'b0;
			signal_loss_alarm <= 1'b0;
			eq_code <= EQ_RESET;
			int_out <= 1'b0;
			int_oe <= 1'b0;
		end else begin
			dpm_live_d <= dpm_live;
			los_live_d <= los_live;
			driver_perf_alarm <= dpm_live;
			signal_loss_alarm <= los_live;
			eq_code <= next_eq;
			int_out <= 1'b0;
			int_oe <= next_int;
		end
	end

	// Reference counts of silent periods, kept apart from the alarm counters so the checks do not lean on them.
	logic [6:0] quiet_ticks;
	logic [7:0] space_ticks;

	always_ff @(posedge ref_clk) begin
		if (sys_rst || dpm_pulse) begin
			quiet_ticks <= 7'h00;
		end else if (tx_tick && quiet_ticks != 7'h7F) begin
			quiet_ticks <= quiet_ticks + 7'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || rx_mark) begin
			space_ticks <= 8'h00;
		end else if (rx_bit_en && space_ticks != 8'hFF) begin
			space_ticks <= space_ticks + 8'h01;
		end
	end

	// Alarm counter checks.
	dpm_rise_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$rose(dpm_live) |-> dpm_cnt == 6'(DPM_LIMIT) ##1 driver_perf_alarm)
		else $error("driver alarm rose at wrong count");
	dpm_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		dpm_live && !dpm_pulse |=> dpm_live)
		else $error("driver alarm dropped without a pulse");
	dpm_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		dpm_pulse |=> !dpm_live ##1 !driver_perf_alarm)
		else $error("driver alarm not cleared by pulse");
	los_rise_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$rose(los_live) |-> los_cnt == LOS_TICKS ##1 signal_loss_alarm)
		else $error("loss alarm rose at wrong count");
	los_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rx_mark |=> los_cnt == 8'h0 && !los_live ##1 !signal_loss_alarm)
		else $error("mark did not restart loss count");
	// Interrupt, equalizer pin, recovered data and loss count step checks.
	int_assert_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		mode_host && (rise_ev & mask) != 2'h0 |=> int_oe)
		else $error("interrupt not raised on alarm");
	int_release_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$fell(int_oe) |-> !$past(mode_host) || (status & $past(mask)) == 2'h0)
		else $error("interrupt released while a status bit was set");
	int_low_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		int_oe |-> !int_out)
		else $error("interrupt driven high");
	eq_pins_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!mode_host |=> eq_code == $past(pin_code))
		else $error("equalizer code not from pins");
	rx_data_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rx_bit_en |=> rx_plus_data == $past(plus_seen || receive_line_a))
		else $error("recovered data mismatch");
	hw_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!mode_host |=> !int_oe)
		else $error("interrupt active in hardware mode");
	cnt_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		los_cnt != $past(los_cnt) |-> $past(rx_bit_en) || $past(rx_mark))
		else $error("space count moved without a bit period");

	// Checks against the reference counts, plus silence count and loss hold checks.
	dpm_window_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$rose(dpm_live) |-> quiet_ticks >= DPM_LO && quiet_ticks <= DPM_HI)
		else $error("driver alarm outside its silence window");
	dpm_late_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		quiet_ticks >= DPM_HI |-> dpm_live)
		else $error("driver alarm missing after long silence");
	dpm_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		dpm_pulse |=> dpm_cnt == 6'h00)
		else $error("monitor pulse did not restart silence count");
	dpm_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		dpm_cnt != $past(dpm_cnt) |-> $past(tx_tick) || $past(dpm_pulse))
		else $error("silence count moved without a transmit period");
	los_exact_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$rose(los_live) |-> space_ticks == LOS_TICKS)
		else $error("loss alarm rose at wrong space count");
	los_late_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		space_ticks >= LOS_TICKS |-> los_live)
		else $error("loss alarm missing after long run of spaces");
	los_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		los_live && !rx_mark |=> los_live)
		else $error("loss alarm dropped without a mark");

	// Status and mode checks.
	status_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise_ev != 2'h0 |=> (status & $past(rise_ev)) == $past(rise_ev))
		else $error("alarm rise did not set status");
	status_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		($past(status) & ~status) != 2'h0 |-> $past(wr_en && hit_status))
		else $error("status bit cleared without a host write");
	int_mask_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		int_oe |-> (status & $past(mask)) != 2'h0)
		else $error("interrupt from a masked bit");
	host_eq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		mode_host |=> eq_code == $past(eq_ctrl))
		else $error("equalizer code not from register in host mode");

	// Recovered data and clock checks.
	rx_mark_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		receive_line_a |-> ##[1:RX_SPAN] rx_plus_data)
		else $error("positive mark not presented");
	rx_minus_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		receive_line_b |-> ##[1:RX_SPAN] rx_minus_data)
		else $error("negative mark not presented");
	rx_clk_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rx_bit_en && !mark_rise |-> ##2 rx_clk)
		else $error("recovered clock not high after bit end");
	rx_align_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		mark_rise |-> ##2 !rx_clk)
		else $error("recovered clock not realigned on mark");

	los_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(signal_loss_alarm));
	dpm_seen_c: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(driver_perf_alarm));
	int_clear_c: cover property (@(posedge ref_clk) disable iff (sys_rst) $fell(int_oe) && mode_host);
	loss_clear_c: cover property (@(posedge ref_clk) disable iff (sys_rst) $fell(signal_loss_alarm));
	eq_host_c: cover property (@(posedge ref_clk) disable iff (sys_rst) mode_host && eq_code != 3'h0);
endmodule : lam_line_alarm_monitor

// ===== lam_line_model.sv
// Purpose: Line model driving transmit monitor and receive line pulses.
// Assumes: One pulse every eight clocks while enabled.
// Notes: Disabled lines rest low, which reads as a space.
`timescale 1ns/1ns
module lam_line_model (
	// Clock
	input wire logic clk,
	// Control
	input wire logic tx_on,
	input wire logic rx_on,
	input wire logic rx_neg,
	// Lines
	output logic monitor_line_a,
	output logic monitor_line_b,
	output logic receive_line_a,
	output logic receive_line_b
);
	logic [3:0] cnt = 4'h0;
	logic [3:0] pul = 4'h0;
	wire fire = cnt[2:0] == 3'h7;
	assign {receive_line_b, receive_line_a, monitor_line_b, monitor_line_a} = pul;
	always @(posedge clk) begin
		cnt <= cnt + 4'h1;
		pul[1:0] <= {2{tx_on & fire}} & {cnt[3], ~cnt[3]};
		pul[3:2] <= {2{rx_on & fire}} & {rx_neg, ~rx_neg};
	end
endmodule : lam_line_model

// ===== line_alarm_monitor_bench.sv
// Purpose: Self-checking bench for the line alarm monitor.
// Assumes: Counts are divided by four for a short run.
// Notes: Host side is driven by the APB tasks below.
`timescale 1ns/1ns
module line_alarm_monitor_bench;
	import lam_pkg::*;
	localparam int DIV = 4;
	logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, tx_on = 1, rx_on = 1, rx_neg = 0;
	logic mode_host = 1, eq_select_0 = 0, eq_select_1 = 0, eq_select_2 = 0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd, prdata;
	logic pready, pslverr, ma, mb, ra, rb, rx_plus_data, rx_minus_data, rx_clk;
	logic driver_perf_alarm, signal_loss_alarm, int_out, int_oe;
	logic [2:0] eq_code, saw = 3'h0;
	int failures = 0, n_tests = 0;
	initial forever #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) saw <= saw | {rx_clk, rx_minus_data, rx_plus_data};
	lam_line_model model (.clk(ref_clk), .tx_on(tx_on), .rx_on(rx_on), .rx_neg(rx_neg), .monitor_line_a(ma),
		.monitor_line_b(mb), .receive_line_a(ra), .receive_line_b(rb));
	lam_line_alarm_monitor #(.BIT_DIVIDE(DIV), .TX_DIVIDE(DIV)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .monitor_line_a(ma), .monitor_line_b(mb), .receive_line_a(ra),
		.receive_line_b(rb), .rx_plus_data(rx_plus_data), .rx_minus_data(rx_minus_data), .rx_clk(rx_clk),
		.mode_host(mode_host), .eq_select_0(eq_select_0), .eq_select_1(eq_select_1), .eq_select_2(eq_select_2),
		.eq_code(eq_code), .driver_perf_alarm(driver_perf_alarm), .signal_loss_alarm(signal_loss_alarm),
		.int_out(int_out), .int_oe(int_oe));
	task automatic print_verdict();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, seen);
			failures++;
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge ref_clk);
		if (i == 20) begin
			failures++;
			print_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_hi(input bit loss);
		int i;
		for (i = 0; i < 40 && (loss ? signal_loss_alarm : driver_perf_alarm) !== 1'b1; i++) @(posedge ref_clk);
		if (i == 40) begin
			failures++;
			print_verdict();
		end
	endtask : wait_hi
	initial begin
		cyc(12);
		sys_rst <= 1'b0;
		apb(0, OFS_MASK, 0);
		chk("mask", rd, 32'h3);
		apb(0, 8'h10, 0);
		chk("unmapped", {rd[30:0], err}, 32'h1);
		tx_on <= 1'b0;
		cyc(236);
		chk("driver early", driver_perf_alarm, 0);
		wait_hi(0);
		cyc(3);
		chk("int", {int_oe, int_out}, 2'b10);
		apb(0, OFS_STATUS, 0);
		chk("status", rd, 32'h2);
		tx_on <= 1'b1;
		cyc(16);
		chk("driver clear", driver_perf_alarm, 0);
		chk("int held", int_oe, 1);
		apb(1, OFS_STATUS, 32'h2);
		cyc(2);
		chk("int release", int_oe, 0);
		$display("test driver done");
		apb(1, OFS_MASK, 0);
		rx_on <= 1'b0;
		cyc(680);
		chk("loss early", signal_loss_alarm, 0);
		wait_hi(1);
		cyc(3);
		chk("int masked", int_oe, 0);
		apb(0, OFS_STATUS, 0);
		chk("loss status", rd, 32'h1);
		apb(1, OFS_MASK, 32'h1);
		cyc(2);
		chk("int unmasked", int_oe, 1);
		{rx_on, rx_neg} <= 2'b11;
		cyc(16);
		chk("loss clear", signal_loss_alarm, 0);
		rx_on <= 1'b0;
		cyc(680);
		chk("loss restart", signal_loss_alarm, 0);
		rx_on <= 1'b1;
		apb(1, OFS_STATUS, 32'h1);
		cyc(2);
		chk("int loss release", int_oe, 0);
		$display("test loss done");
		mode_host <= 1'b0;
		for (int c = 0; c < 8; c++) begin
			{eq_select_2, eq_select_1, eq_select_0} <= c[2:0];
			cyc(3);
			chk("eq pins", eq_code, c[2:0]);
		end
		tx_on <= 1'b0;
		cyc(280);
		chk("int hw mode", int_oe, 0);
		tx_on <= 1'b1;
		apb(1, OFS_STATUS, 32'h3);
		mode_host <= 1'b1;
		apb(1, OFS_CTRL, 32'h5);
		cyc(3);
		chk("eq host", eq_code, 3'h5);
		apb(0, OFS_CTRL, 0);
		chk("ctrl", rd, 32'h5);
		apb(0, OFS_LIVE, 0);
		chk("live", rd, 32'h54);
		chk("recovered", saw, 3'h7);
		$display("test modes done");
		print_verdict();
	end
endmodule : line_alarm_monitor_bench
